// ===== common/lpc_decode_pkg.sv
package lpc_decode_pkg;

  // slave cpu side register select codes
  localparam logic [1:0]  CPU_OFF_CTRL0   = 2'h0;
  localparam logic [1:0]  CPU_OFF_BASE_HI = 2'h1;
  localparam logic [1:0]  CPU_OFF_BASE_LO = 2'h2;

  // host_if_control_zero fields
  localparam int          EN3_POS         = 7;
  localparam int          EN2_POS         = 6;
  localparam int          EN1_POS         = 5;
  localparam logic [7:0]  CTRL0_RESET     = 8'h00;
  localparam logic [7:0]  BASE_HI_RESET   = 8'h00;
  localparam logic [7:0]  BASE_LO_RESET   = 8'h00;

  // fixed host i/o addresses
  localparam logic [15:0] CH1_DATA_ADDR   = 16'h0060;
  localparam logic [15:0] CH1_STAT_ADDR   = 16'h0064;
  localparam logic [15:0] CH2_DATA_ADDR   = 16'h0062;
  localparam logic [15:0] CH2_STAT_ADDR   = 16'h0066;
  // channel 3 answers the 32-byte aligned window that holds its base
  localparam int          CH3_WIN_BITS    = 5;

  // lad nibble codes
  localparam logic [3:0]  LAD_START       = 4'h0;
  localparam logic [3:0]  CT_IO_READ      = 4'h0;
  localparam logic [3:0]  CT_IO_WRITE     = 4'h2;
  localparam logic [3:0]  SYNC_READY      = 4'h0;
  localparam logic [3:0]  LAD_IDLE        = 4'hf;

  localparam logic [1:0]  CH_NONE         = 2'h0;
  localparam logic [1:0]  CH_1            = 2'h1;
  localparam logic [1:0]  CH_2            = 2'h2;
  localparam logic [1:0]  CH_3            = 2'h3;

  localparam logic [1:0]  NIB_LAST        = 2'h3;
  localparam logic [1:0]  NIB_SECOND      = 2'h1;

  typedef enum logic [3:0] {
    ST_IDLE, ST_TYPE, ST_ADDR, ST_WDATA, ST_TAR1, ST_SYNC, ST_RDATA, ST_TAR2, ST_SKIP
  } lpc_state_t;

endpackage

// ===== hw/lpc_channel_enable_decode.sv
`timescale 1ns/100ps
`default_nettype none
module lpc_channel_enable_decode
  import lpc_decode_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  input  wire logic        cpu_wr,
  input  wire logic [1:0]  cpu_addr,
  input  wire logic [7:0]  cpu_wdata,
  output logic      [7:0]  cpu_rdata,
  input  wire logic        legacy_host_if_enable_bit,
  input  wire logic        lclk,
  input  wire logic        lframe_n,
  input  wire logic [3:0]  lad_in,
  output logic      [3:0]  lad_out,
  output logic             lad_oe,
  output logic             lpc_active,
  output logic             host_wr_pulse,
  output logic             host_rd_pulse,
  output logic      [1:0]  host_chan,
  output logic      [15:0] host_addr,
  output logic      [7:0]  host_wdata,
  input  wire logic [7:0]  host_rd_data
);

  logic [7:0]  ctrl0;
  logic [7:0]  base_hi;
  logic [7:0]  base_lo;
  logic [7:0]  next_ctrl0;
  logic [7:0]  next_base_hi;
  logic [7:0]  next_base_lo;

  // legacy enable intentionally unread: lpc decode ignores it
  logic        unused_legacy;
  assign unused_legacy = legacy_host_if_enable_bit;

  always_comb begin
    next_ctrl0   = ctrl0;
    next_base_hi = base_hi;
    next_base_lo = base_lo;
    if (cpu_wr) begin
      case (cpu_addr)
        CPU_OFF_CTRL0: begin
          // only the three enables are held here
          next_ctrl0 = cpu_wdata & 8'he0;
        end
        CPU_OFF_BASE_HI: next_base_hi = cpu_wdata;
        CPU_OFF_BASE_LO: next_base_lo = cpu_wdata;
        default: ;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl0   <= CTRL0_RESET;
      base_hi <= BASE_HI_RESET;
      base_lo <= BASE_LO_RESET;
    end else begin
      ctrl0   <= next_ctrl0;
      base_hi <= next_base_hi;
      base_lo <= next_base_lo;
    end
  end

  always_comb begin
    case (cpu_addr)
      CPU_OFF_CTRL0:   cpu_rdata = ctrl0;
      CPU_OFF_BASE_HI: cpu_rdata = base_hi;
      CPU_OFF_BASE_LO: cpu_rdata = base_lo;
      default:         cpu_rdata = 8'h00;
    endcase
  end

  assign lpc_active = ctrl0[EN3_POS] | ctrl0[EN2_POS] | ctrl0[EN1_POS];

  // pin synchronisers; first stage feeds only the second
  logic       lclk_s1;
  logic       lclk_s2;
  logic       lclk_d;
  logic       lframe_s1;
  logic       lframe_s2;
  logic [3:0] lad_s1;
  logic [3:0] lad_s2;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      lclk_s1   <= 1'b0;
      lclk_s2   <= 1'b0;
      lclk_d    <= 1'b0;
      lframe_s1 <= 1'b1;
      lframe_s2 <= 1'b1;
      lad_s1    <= LAD_IDLE;
      lad_s2    <= LAD_IDLE;
    end else begin
      lclk_s1   <= lclk;
      lclk_s2   <= lclk_s1;
      lclk_d    <= lclk_s2;
      lframe_s1 <= lframe_n;
      lframe_s2 <= lframe_s1;
      lad_s1    <= lad_in;
      lad_s2    <= lad_s1;
    end
  end

  logic lclk_rise;
  assign lclk_rise = lclk_s2 & ~lclk_d;

  function automatic logic [1:0] chan_hit(input logic [15:0] a, input logic [7:0] en,
                                          input logic [15:0] base);
    if (en[EN1_POS] && (a == CH1_DATA_ADDR || a == CH1_STAT_ADDR)) begin
      chan_hit = CH_1;
    end else if (en[EN2_POS] && (a == CH2_DATA_ADDR || a == CH2_STAT_ADDR)) begin
      chan_hit = CH_2;
    end else if (en[EN3_POS] && a[15:CH3_WIN_BITS] == base[15:CH3_WIN_BITS]) begin
      chan_hit = CH_3;
    end else begin
      chan_hit = CH_NONE;
    end
  endfunction

  lpc_state_t  state;
  lpc_state_t  next_state;
  logic [1:0]  cnt;
  logic [1:0]  next_cnt;
  logic        is_write;
  logic        next_is_write;
  logic [15:0] addr_sh;
  logic [15:0] next_addr_sh;
  logic [7:0]  rd_hold;
  logic [7:0]  next_rd_hold;
  logic [3:0]  next_lad_out;
  logic        next_lad_oe;
  logic        next_wr_pulse;
  logic        next_rd_pulse;
  logic [1:0]  next_host_chan;
  logic [7:0]  next_host_wdata;
  logic [15:0] full_addr;
  logic [1:0]  hit;

  assign full_addr = {addr_sh[11:0], lad_s2};
  assign hit       = chan_hit(full_addr, ctrl0, {base_hi, base_lo});

  always_comb begin
    next_state      = state;
    next_cnt        = cnt;
    next_is_write   = is_write;
    next_addr_sh    = addr_sh;
    next_rd_hold    = rd_hold;
    next_lad_out    = lad_out;
    next_lad_oe     = lad_oe;
    next_wr_pulse   = 1'b0;
    next_rd_pulse   = 1'b0;
    next_host_chan  = host_chan;
    next_host_wdata = host_wdata;
    if (lclk_rise) begin
      next_cnt = cnt + 2'd1;
      if (!lframe_s2) begin
        // frame asserted restarts or aborts any cycle
        next_lad_oe = 1'b0;
        next_cnt    = 2'd0;
        next_state  = (lad_s2 == LAD_START && lpc_active) ? ST_TYPE : ST_IDLE;
      end else begin
        case (state)
          ST_TYPE: begin
            next_cnt      = 2'd0;
            next_is_write = (lad_s2 == CT_IO_WRITE);
            if (lad_s2 == CT_IO_READ || lad_s2 == CT_IO_WRITE) begin
              next_state = ST_ADDR;
            end else begin
              next_state = ST_SKIP;
            end
          end
          ST_ADDR: begin
            next_addr_sh = full_addr;
            if (cnt == NIB_LAST) begin
              next_cnt       = 2'd0;
              next_host_chan = hit;
              if (hit == CH_NONE) begin
                next_state = ST_SKIP;
              end else if (is_write) begin
                next_state = ST_WDATA;
              end else begin
                next_state    = ST_TAR1;
                next_rd_pulse = 1'b1;
              end
            end
          end
          ST_WDATA: begin
            if (cnt == NIB_SECOND) begin
              next_host_wdata[7:4] = lad_s2;
              next_wr_pulse        = 1'b1;
              next_cnt             = 2'd0;
              next_state           = ST_TAR1;
            end else begin
              next_host_wdata[3:0] = lad_s2;
            end
          end
          ST_TAR1: begin
            if (cnt == NIB_SECOND) begin
              next_rd_hold = host_rd_data;
              next_lad_out = SYNC_READY;
              next_lad_oe  = 1'b1;
              next_state   = ST_SYNC;
            end
          end
          ST_SYNC: begin
            next_cnt = 2'd0;
            if (is_write) begin
              next_lad_out = LAD_IDLE;
              next_state   = ST_TAR2;
            end else begin
              next_lad_out = rd_hold[3:0];
              next_state   = ST_RDATA;
            end
          end
          ST_RDATA: begin
            next_lad_out = rd_hold[7:4];
            if (cnt == NIB_SECOND) begin
              next_lad_out = LAD_IDLE;
              next_state   = ST_TAR2;
            end
          end
          ST_TAR2: begin
            next_lad_oe = 1'b0;
            next_state  = ST_IDLE;
          end
          ST_IDLE, ST_SKIP: next_lad_oe = 1'b0;
          default: begin
            next_lad_oe = 1'b0;
            next_state  = ST_IDLE;
          end
        endcase
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state         <= ST_IDLE;
      cnt           <= 2'd0;
      is_write      <= 1'b0;
      addr_sh       <= 16'h0000;
      rd_hold       <= 8'h00;
      lad_out       <= LAD_IDLE;
      lad_oe        <= 1'b0;
      host_wr_pulse <= 1'b0;
      host_rd_pulse <= 1'b0;
      host_chan     <= CH_NONE;
      host_wdata    <= 8'h00;
    end else begin
      state         <= next_state;
      cnt           <= next_cnt;
      is_write      <= next_is_write;
      addr_sh       <= next_addr_sh;
      rd_hold       <= next_rd_hold;
      lad_out       <= next_lad_out;
      lad_oe        <= next_lad_oe;
      host_wr_pulse <= next_wr_pulse;
      host_rd_pulse <= next_rd_pulse;
      host_chan     <= next_host_chan;
      host_wdata    <= next_host_wdata;
    end
  end

  assign host_addr = addr_sh;

endmodule // lpc_channel_enable_decode
`default_nettype wire

// ===== tb/lpc_decode_properties.sv
`timescale 1ns/100ps
`default_nettype none
module lpc_decode_checker
  import lpc_decode_pkg::*;
(
  input wire logic        ref_clk,
  input wire logic        rst_n,
  input wire logic        cpu_wr,
  input wire logic [1:0]  cpu_addr,
  input wire logic [7:0]  cpu_wdata,
  input wire logic [3:0]  lad_out,
  input wire logic        lad_oe,
  input wire logic        lpc_active,
  input wire logic        host_wr_pulse,
  input wire logic        host_rd_pulse,
  input wire logic [1:0]  host_chan,
  input wire logic [15:0] host_addr
);
  logic [7:0]  ctl, next_ctl;
  logic [15:0] base, next_base;
  logic        pls;
  assign pls = host_wr_pulse | host_rd_pulse;
  always_comb begin
    next_ctl = (cpu_wr && cpu_addr == CPU_OFF_CTRL0) ? cpu_wdata : ctl;
    next_base = base;
    if (cpu_wr && cpu_addr == CPU_OFF_BASE_HI) next_base[15:8] = cpu_wdata;
    if (cpu_wr && cpu_addr == CPU_OFF_BASE_LO) next_base[7:0] = cpu_wdata;
  end
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctl  <= CTRL0_RESET;
      base <= {BASE_HI_RESET, BASE_LO_RESET};
    end else begin
      ctl  <= next_ctl;
      base <= next_base;
    end
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  a_active_map: assert property (lpc_active == |ctl[7:5])
    else $error("active bad");
  a_ch1_decode: assert property (pls && host_chan == CH_1 |-> ctl[EN1_POS] &&
    (host_addr == CH1_DATA_ADDR || host_addr == CH1_STAT_ADDR)) else $error("ch1 bad");
  a_ch2_decode: assert property (pls && host_chan == CH_2 |-> ctl[EN2_POS] &&
    (host_addr == CH2_DATA_ADDR || host_addr == CH2_STAT_ADDR)) else $error("ch2 bad");
  a_ch3_window: assert property (pls && host_chan == CH_3 |-> ctl[EN3_POS] &&
    host_addr[15:5] == base[15:5]) else $error("ch3 bad");
  a_chan_none: assert property (pls |-> host_chan != CH_NONE)
    else $error("no chan");
  a_sync_first: assert property ($rose(lad_oe) |-> lad_out == SYNC_READY)
    else $error("sync bad");
  a_drive_enabled: assert property ($rose(lad_oe) |-> lpc_active)
    else $error("drive bad");
  a_pulse_once: assert property (host_wr_pulse |-> !host_rd_pulse ##1 !host_wr_pulse)
    else $error("pulse bad");
endmodule // lpc_decode_checker
bind lpc_channel_enable_decode lpc_decode_checker i_lpc_decode_checker (.ref_clk(ref_clk),
  .rst_n(rst_n), .cpu_wr(cpu_wr), .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata),
  .lad_out(lad_out), .lad_oe(lad_oe), .lpc_active(lpc_active), .host_chan(host_chan),
  .host_wr_pulse(host_wr_pulse), .host_rd_pulse(host_rd_pulse), .host_addr(host_addr));
`default_nettype wire

// ===== tb/lpc_host_model.sv
`timescale 1ns/100ps
`default_nettype none
module lpc_host_model (
  output logic            lclk = 1'b0,
  output logic            lframe_n = 1'b1,
  output logic      [3:0] lad_in,
  input  wire logic [3:0] lad_out,
  input  wire logic       lad_oe
);
  logic       drv = 1'b0;
  logic [3:0] val = 4'hf;
  // released lad rests at its pull-up level
  assign lad_in = lad_oe ? lad_out : (drv ? val : 4'hf);
  always #40 lclk = ~lclk;
  // drive on the falling edge so the synchronised rise never races the nibble
  task automatic xfer(input logic [3:0] ct, input logic [15:0] a, input logic [7:0] d,
                      output logic hit, output logic [7:0] rd);
    logic [3:0] q[$];
    q = '{4'h0, ct, a[15:12], a[11:8], a[7:4], a[3:0], d[3:0], d[7:4], 4'hf};
    if (ct != 4'h2) q = '{4'h0, ct, a[15:12], a[11:8], a[7:4], a[3:0], 4'hf};
    hit = 1'b0;
    rd = 8'h00;
    foreach (q[i]) begin
      @(negedge lclk);
      lframe_n = (i != 0);
      drv = 1'b1;
      val = q[i];
    end
    @(negedge lclk);
    drv = 1'b0;
    for (int k = 0; k < 8 && !hit; k++) begin
      @(negedge lclk);
      hit = lad_oe && lad_in === 4'h0;
    end
    if (hit && ct == 4'h0) begin
      @(negedge lclk) rd[3:0] = lad_in;
      @(negedge lclk) rd[7:4] = lad_in;
    end
    repeat (3) @(negedge lclk);
  endtask
endmodule // lpc_host_model
`default_nettype wire

// ===== tb/tb_lpc_channel_enable_decode.sv
`timescale 1ns/100ps
`default_nettype none
module tb_lpc_channel_enable_decode
  import lpc_decode_pkg::*;
;
  logic        ref_clk = 1'b0, rst_n = 1'b0, cpu_wr = 1'b0, legacy = 1'b0;
  logic [1:0]  cpu_addr = 2'h0, host_chan;
  logic [7:0]  cpu_wdata = 8'h00, host_rd_data = 8'h00, cpu_rdata, host_wdata, rd;
  logic [3:0]  lad_in, lad_out;
  logic [15:0] host_addr;
  logic        lclk, lframe_n, lad_oe, lpc_active, host_wr_pulse, host_rd_pulse, hit;
  int          errors = 0, n_tests = 0, cycles = 0;
  int          n_wr = 0, n_rd = 0;
  logic [1:0]  seen_chan = 2'h0;
  logic [15:0] seen_addr = 16'h0000;
  logic [7:0]  seen_wdata = 8'h00;
  lpc_channel_enable_decode i_lpc_channel_enable_decode (.ref_clk(ref_clk), .rst_n(rst_n),
    .cpu_wr(cpu_wr), .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata), .cpu_rdata(cpu_rdata),
    .legacy_host_if_enable_bit(legacy), .lclk(lclk), .lframe_n(lframe_n), .lad_in(lad_in),
    .lad_out(lad_out), .lad_oe(lad_oe), .lpc_active(lpc_active), .host_chan(host_chan),
    .host_wr_pulse(host_wr_pulse), .host_rd_pulse(host_rd_pulse), .host_addr(host_addr),
    .host_wdata(host_wdata), .host_rd_data(host_rd_data));
  lpc_host_model i_lpc_host_model (.lclk(lclk), .lframe_n(lframe_n), .lad_in(lad_in),
    .lad_out(lad_out), .lad_oe(lad_oe));
  always #4 ref_clk = ~ref_clk;
  // pulses stand one ref_clk cycle, so catch what the user side is handed
  always @(posedge ref_clk) begin
    if (host_wr_pulse) begin
      n_wr       <= n_wr + 1;
      seen_chan  <= host_chan;
      seen_addr  <= host_addr;
      seen_wdata <= host_wdata;
    end else if (host_rd_pulse) begin
      n_rd      <= n_rd + 1;
      seen_chan <= host_chan;
      seen_addr <= host_addr;
    end
  end
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      errors++;
      conclude();
    end
  end
  task automatic chk(input string s, input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", s, exp, got);
    end
  endtask
  task automatic cwr(input logic [1:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    cpu_wr <= 1'b1;
    cpu_addr <= a;
    cpu_wdata <= d;
    @(posedge ref_clk);
    cpu_wr <= 1'b0;
  endtask
  task automatic crd(input logic [1:0] a, input logic [7:0] exp);
    @(posedge ref_clk);
    cpu_addr <= a;
    @(negedge ref_clk);
    chk("cpu_rdata", cpu_rdata, exp);
  endtask
  task automatic t_regs;
    crd(CPU_OFF_CTRL0, CTRL0_RESET);
    crd(CPU_OFF_BASE_HI, BASE_HI_RESET);
    i_lpc_host_model.xfer(CT_IO_WRITE, CH1_DATA_ADDR, 8'h11, hit, rd);
    chk("idle hit", hit, 1'b0);
    cwr(CPU_OFF_CTRL0, 8'hff);
    crd(CPU_OFF_CTRL0, 8'he0);
    chk("lpc_active", lpc_active, 1'b1);
    cwr(CPU_OFF_BASE_HI, 8'h12);
    cwr(CPU_OFF_BASE_LO, 8'h34);
    crd(CPU_OFF_BASE_LO, 8'h34);
    crd(2'h3, 8'h00);
  endtask
  task automatic t_decode;
    logic [15:0] adr[6] = '{16'h0060, 16'h0064, 16'h0062, 16'h0066, 16'h1220, 16'h1240};
    logic [1:0]  own[6] = '{CH_1, CH_1, CH_2, CH_2, CH_3, CH_NONE};
    logic [7:0]  en[3] = '{8'h20, 8'h40, 8'h80};
    int          n0;
    // one channel at a time, so a leak from a disabled channel shows as a hit
    for (int e = 0; e < 3; e++) begin
      cwr(CPU_OFF_CTRL0, en[e]);
      for (int i = 0; i < 6; i++) begin
        n0 = n_wr;
        i_lpc_host_model.xfer(CT_IO_WRITE, adr[i], 8'h5a, hit, rd);
        chk("hit", hit, own[i] == e + 1);
        chk("wr pulses", 16'(n_wr - n0), own[i] == e + 1);
        if (own[i] == e + 1) begin
          chk("wr chan", seen_chan, own[i]);
          chk("wr addr", seen_addr, adr[i]);
          chk("wr data", seen_wdata, 8'h5a);
        end
      end
    end
  endtask
  task automatic t_types;
    logic [3:0] ct[5] = '{4'h4, 4'h6, 4'h8, 4'h1, 4'h3};
    int         r0;
    cwr(CPU_OFF_CTRL0, 8'he0);
    legacy <= 1'b1;
    host_rd_data <= 8'ha5;
    r0 = n_rd;
    i_lpc_host_model.xfer(CT_IO_READ, CH2_STAT_ADDR, 8'h00, hit, rd);
    chk("read sync", hit, 1'b1);
    chk("read data", rd, 8'ha5);
    chk("rd pulses", 16'(n_rd - r0), 16'h0001);
    chk("rd chan", seen_chan, CH_2);
    chk("rd addr", seen_addr, CH2_STAT_ADDR);
    foreach (ct[i]) begin
      r0 = n_rd + n_wr;
      i_lpc_host_model.xfer(ct[i], CH1_DATA_ADDR, 8'h00, hit, rd);
      chk("other type", hit, 1'b0);
      chk("other pulses", 16'(n_rd + n_wr - r0), 16'h0000);
    end
    legacy <= 1'b0;
  endtask
  task automatic t_reset;
    cwr(CPU_OFF_CTRL0, 8'he0);
    cwr(CPU_OFF_BASE_LO, 8'h40);
    @(posedge ref_clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    crd(CPU_OFF_CTRL0, CTRL0_RESET);
    crd(CPU_OFF_BASE_LO, BASE_LO_RESET);
    chk("lpc_active", lpc_active, 1'b0);
    i_lpc_host_model.xfer(CT_IO_WRITE, CH1_STAT_ADDR, 8'h33, hit, rd);
    chk("reset hit", hit, 1'b0);
  endtask
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge ref_clk);
    rst_n <= 1'b1;
    t_regs();
    t_decode();
    t_types();
    t_reset();
    conclude();
  end
endmodule // tb_lpc_channel_enable_decode
`default_nettype wire
